//--- verilog/sac_pkg.sv
// Constants, types and helpers of the converter control block
package sac_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS = 10;
    localparam int CONV_WARP_NS = 1400;
    localparam int CONV_NORMAL_NS = 1600;
    localparam int CONV_IMPULSE_NS = 1800;
    localparam int ACQ_NS = 450;
    localparam logic [7:0] CONV_WARP_CYC = 8'((CONV_WARP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CONV_NORMAL_CYC = 8'((CONV_NORMAL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CONV_IMPULSE_CYC = 8'((CONV_IMPULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ACQ_CYC = 8'((ACQ_NS + CLK_NS - 1) / CLK_NS);

    // ----------------------------------------
    // Encodings and positions
    // ----------------------------------------
    localparam logic [1:0] MODE_WARP = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h1;
    localparam logic [1:0] MODE_IMPULSE = 2'h2;
    localparam logic CODING_TWOS = 1'h0;
    localparam logic CLK_INTERNAL = 1'h0;
    localparam logic RDC_AFTER = 1'h1;
    localparam logic [3:0] LAST_BIT = 4'hf;
    localparam logic [1:0] PH_SHIFT = 2'h0;
    localparam logic [1:0] PH_LAST = 2'h3;
    localparam int BUS_SERIAL_DATA_OUT = 15;
    localparam int BUS_SCLK = 14;
    localparam int BUS_SYNC = 13;
    localparam logic [12:0] PINS_RST = 13'h1c00;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_ACQ = 2'b01,
        SAC_CONV = 2'b10,
        SAC_SHIFT = 2'b11
    } sac_state_t;

    typedef struct packed {
        logic convert_start_n_n;
        logic cs_n;
        logic rd_n;
        logic pd;
        logic coding;
        logic ser;
        logic swap;
        logic ext;
        logic rdc;
        logic inv;
        logic [1:0] mode;
        logic done;
    } sac_pins_t;

    typedef struct packed {
        sac_state_t state;
        logic [7:0] cnt;
        logic [15:0] word;
        logic [15:0] xword;
        logic [15:0] shreg;
        logic [3:0] bitn;
        logic [1:0] phase;
        logic sh_on;
        logic busy;
        logic ovr;
        logic pending;
        logic low_power;
        sac_pins_t s1;
        sac_pins_t s2;
        sac_pins_t s3;
        sac_pins_t lvl;
        logic [15:0] data;
        logic [15:0] oe;
    } sac_st_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic done;
    } sac_lnk_t;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] sac_coded(input logic [15:0] w, input logic coding);
        sac_coded = (coding == CODING_TWOS) ? {~w[15], w[14:0]} : w;
    endfunction : sac_coded

    function automatic sac_pins_t sac_filter(input sac_pins_t a, input sac_pins_t b, input sac_pins_t hold);
        sac_filter = sac_pins_t'((a & b) | (hold & (a ^ b)));
    endfunction : sac_filter

    function automatic logic [7:0] sac_conv_cyc(input logic [1:0] mode);
        case (mode)
            MODE_WARP: sac_conv_cyc = CONV_WARP_CYC;
            MODE_NORMAL: sac_conv_cyc = CONV_NORMAL_CYC;
            default: sac_conv_cyc = CONV_IMPULSE_CYC;
        endcase
    endfunction : sac_conv_cyc
endpackage : sac_pkg

//--- verilog/sac_ext_shift.sv
// Serial shifter on the host-supplied bit clock
`timescale 1ns/10ps
module sac_ext_shift (
    input wire logic i_sclk_link,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_enable,
    input wire logic [15:0] i_word,
    output logic o_serial_data_out,
    output logic o_serial_data_out_oe,
    output logic o_done
);
    import sac_pkg::*;

    sac_lnk_t lnk;
    sac_lnk_t next_lnk;

    // ----------------------------------------
    // Bit counter, cleared while deselected
    // ----------------------------------------
    always_comb begin
        next_lnk = lnk;
        if (~i_rd_n & ~lnk.done) begin
            next_lnk.cnt = lnk.cnt + 4'h1;
            next_lnk.done = (lnk.cnt == LAST_BIT);
        end
    end

    always_ff @(posedge i_sclk_link or posedge i_cs_n) begin
        if (i_cs_n) begin
            lnk <= '0;
        end else begin
            lnk <= next_lnk;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_serial_data_out = i_word[4'(LAST_BIT - lnk.cnt)];
    assign o_serial_data_out_oe = i_enable & ~i_cs_n & ~i_rd_n;
    assign o_done = lnk.done;
endmodule : sac_ext_shift

//--- verilog/sac_adc_ctrl.sv
// Conversion control and output port of the converter
`timescale 1ns/10ps
// What this block does
// - Running conversion ignores start and power-down
// - Start works whatever select and read
// - Low-power mode held start restarts automatically
// - Auto restart only in low-power mode
// - Low-power mode idles after each conversion
// - Output port works during acquisition
// - Outputs float unless select and read low
// - Coding input picks twos or binary
// - Internal-clock serial signals share parallel bus pins; external data has its own output
// - Parallel read after or during conversion
// - Byte order input swaps bus halves
// - Serial sends 16 bits MSB first
// - Internal serial bit stable across both edges; external bit changes on rising edge
// - Internal mode makes bit clock, frame strobe
// - Internal clock and strobe may invert
// - Timing input picks after or during
// - Internal-clock read-after keeps busy until 16 bits
// - Internal-clock read-during shifts only in first half
// - External clock gated by select
// - Unfinished external read in read-during pulses overrun flag
module sac_adc_ctrl (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sclk_link,
    input wire logic i_convert_start_n,
    input wire logic i_power_down_input,
    input wire logic [1:0] i_mode_sel,
    input wire logic i_chip_select_n,
    input wire logic i_read_enable_n,
    input wire logic i_output_coding_select,
    input wire logic i_serial_parallel_select,
    input wire logic i_byte_order_select,
    input wire logic i_clock_source_select,
    input wire logic i_read_timing_or_chain_in,
    input wire logic i_sclk_invert,
    input wire logic [15:0] i_sar_code,
    output logic o_busy,
    output logic [15:0] o_data,
    output logic [15:0] o_data_oe,
    output logic o_read_overrun_flag,
    output logic o_low_power,
    output logic o_ext_serial_data_out,
    output logic o_ext_serial_data_out_oe
);
    import sac_pkg::*;

    sac_st_t st;
    sac_st_t next_st;
    sac_pins_t pins_raw;
    sac_pins_t nl;
    logic link_done;
    logic ext_en;
    logic fall;
    logic auto_ok;
    logic int_ser;
    logic ext_ser;
    logic sel;
    logic go;
    logic acq;
    logic ld;
    logic [15:0] ld_word;
    logic [15:0] bw;

    // ----------------------------------------
    // Pin gathering
    // ----------------------------------------
    assign pins_raw = {i_convert_start_n, i_chip_select_n, i_read_enable_n, i_power_down_input,
                       i_output_coding_select, i_serial_parallel_select, i_byte_order_select,
                       i_clock_source_select, i_read_timing_or_chain_in, i_sclk_invert,
                       i_mode_sel, link_done};
    assign ext_en = st.lvl.ser & (st.lvl.ext != CLK_INTERNAL);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        nl = sac_filter(st.s2, st.s3, st.lvl);
        next_st.s1 = pins_raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.lvl = nl;
        fall = st.lvl.convert_start_n_n & ~nl.convert_start_n_n;
        auto_ok = (nl.mode == MODE_IMPULSE) & ~nl.convert_start_n_n & ~nl.pd;
        int_ser = nl.ser & (nl.ext == CLK_INTERNAL);
        ext_ser = nl.ser & (nl.ext != CLK_INTERNAL);
        sel = ~nl.cs_n & ~nl.rd_n;
        go = 1'b0;
        acq = 1'b0;
        ld = 1'b0;
        ld_word = st.word;
        bw = '0;
        next_st.ovr = 1'b0;
        if (~st.lvl.done & nl.done) begin
            next_st.pending = 1'b0;
        end

        // Internal bit clock shifter
        if (st.sh_on) begin
            next_st.phase = st.phase + 2'h1;
            if ((st.phase == PH_SHIFT) && (st.bitn != 4'h0)) begin
                next_st.shreg = {st.shreg[14:0], 1'b0};
            end
            if (st.phase == PH_LAST) begin
                if (st.bitn == LAST_BIT) begin
                    next_st.sh_on = 1'b0;
                end else begin
                    next_st.bitn = st.bitn + 4'h1;
                end
            end
        end

        case (st.state)
            SAC_IDLE: begin
                if (fall & ~nl.pd) begin
                    go = 1'b1;
                end else if (auto_ok) begin
                    acq = 1'b1;
                end
            end
            SAC_ACQ: begin
                if (st.cnt != 8'h00) begin
                    next_st.cnt = st.cnt - 8'h01;
                end else if (auto_ok) begin
                    go = 1'b1;
                end else begin
                    next_st.state = SAC_IDLE;
                end
            end
            SAC_CONV: begin
                if (st.cnt != 8'h00) begin
                    next_st.cnt = st.cnt - 8'h01;
                end else begin
                    next_st.word = i_sar_code;
                    if (ext_ser & (nl.rdc != RDC_AFTER) & st.pending) begin
                        next_st.ovr = 1'b1;
                    end
                    next_st.pending = ext_ser;
                    if (int_ser & (nl.rdc == RDC_AFTER)) begin
                        ld = 1'b1;
                        ld_word = i_sar_code;
                        next_st.state = SAC_SHIFT;
                    end else if (auto_ok) begin
                        acq = 1'b1;
                    end else begin
                        next_st.state = SAC_IDLE;
                        next_st.busy = 1'b0;
                    end
                end
            end
            SAC_SHIFT: begin
                if (~st.sh_on) begin
                    if (auto_ok) begin
                        acq = 1'b1;
                    end else begin
                        next_st.state = SAC_IDLE;
                        next_st.busy = 1'b0;
                    end
                end
            end
            default: begin
                next_st.state = SAC_IDLE;
                next_st.busy = 1'b0;
            end
        endcase

        if (acq) begin
            next_st.state = SAC_ACQ;
            next_st.cnt = ACQ_CYC - 8'h01;
            next_st.busy = 1'b0;
        end
        if (go) begin
            next_st.state = SAC_CONV;
            next_st.cnt = sac_conv_cyc(nl.mode) - 8'h01;
            next_st.busy = 1'b1;
            if (int_ser & (nl.rdc != RDC_AFTER)) begin
                ld = 1'b1;
                ld_word = st.word;
            end
        end
        if (ld) begin
            next_st.shreg = sac_coded(ld_word, nl.coding);
            next_st.sh_on = 1'b1;
            next_st.bitn = 4'h0;
            next_st.phase = 2'h0;
        end
        next_st.low_power = (nl.mode == MODE_IMPULSE) &
                            ((next_st.state == SAC_IDLE) | (next_st.state == SAC_ACQ));
        next_st.xword = sac_coded(next_st.word, nl.coding);

        // Output port, active in every state
        next_st.data = '0;
        next_st.oe = '0;
        if (~nl.ser) begin
            bw = sac_coded(st.word, nl.coding);
            next_st.data = nl.swap ? {bw[7:0], bw[15:8]} : bw;
            next_st.oe = {16{sel}};
        end else if (int_ser) begin
            next_st.data[BUS_SERIAL_DATA_OUT] = st.shreg[15];
            next_st.data[BUS_SCLK] = (st.sh_on & st.phase[1]) ^ nl.inv;
            next_st.data[BUS_SYNC] = st.sh_on ^ nl.inv;
            next_st.oe[BUS_SERIAL_DATA_OUT] = sel;
            next_st.oe[BUS_SCLK] = sel;
            next_st.oe[BUS_SYNC] = sel;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st <= '0;
            st.s1 <= PINS_RST;
            st.s2 <= PINS_RST;
            st.s3 <= PINS_RST;
            st.lvl <= PINS_RST;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Host clock serial path
    // ----------------------------------------
    sac_ext_shift u_ext (
        .i_sclk_link(i_sclk_link),
        .i_cs_n(i_chip_select_n),
        .i_rd_n(i_read_enable_n),
        .i_enable(ext_en),
        .i_word(st.xword),
        .o_serial_data_out(o_ext_serial_data_out),
        .o_serial_data_out_oe(o_ext_serial_data_out_oe),
        .o_done(link_done)
    );

    assign o_busy = st.busy;
    assign o_data = st.data;
    assign o_data_oe = st.oe;
    assign o_read_overrun_flag = st.ovr;
    assign o_low_power = st.low_power;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    localparam int A_CONV_LO = int'(CONV_WARP_CYC);
    localparam int A_CONV_HI = int'(CONV_IMPULSE_CYC);
    localparam int A_HALF = int'(CONV_WARP_CYC) / 2;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    sequence s_conv_begin;
        (st.state != SAC_CONV) ##1 (st.state == SAC_CONV);
    endsequence

    sequence s_shift_begin;
        !st.sh_on ##1 st.sh_on;
    endsequence

    a_conv_no_abort: assert property ((st.state == SAC_CONV) && (st.cnt != 8'h00) |=>
        (st.state == SAC_CONV) && o_busy)
        else $error("conversion left early");

    a_conv_length: assert property (s_conv_begin |-> ##[A_CONV_LO:A_CONV_HI] (st.state != SAC_CONV))
        else $error("conversion length wrong");

    a_start_any_sel: assert property ((st.state == SAC_IDLE) && fall && !nl.pd |=>
        (st.state == SAC_CONV))
        else $error("start edge not taken");

    a_auto_restart: assert property ((st.state == SAC_ACQ) && (st.cnt == 8'h00) && auto_ok |=>
        (st.state == SAC_CONV) && o_busy)
        else $error("no automatic restart");

    a_no_auto_fast: assert property ((st.state == SAC_IDLE) && (nl.mode != MODE_IMPULSE) |=>
        (st.state != SAC_ACQ))
        else $error("auto restart outside low-power mode");

    a_low_power_idle: assert property (o_low_power |-> !o_busy)
        else $error("low-power state while busy");

    a_hiz_deselect: assert property ((nl.cs_n || nl.rd_n) |=> (o_data_oe == 16'h0000))
        else $error("bus driven while deselected");

    a_parallel_word: assert property (!nl.ser && !nl.swap && (nl.coding != CODING_TWOS) |=>
        (o_data == $past(st.word)))
        else $error("parallel word wrong");

    a_shift_len: assert property (s_shift_begin |-> ##63 st.sh_on ##1 !st.sh_on)
        else $error("serial frame not 16 bits");

    a_bit_stable: assert property (st.sh_on && (st.phase != PH_SHIFT) |=> $stable(st.shreg))
        else $error("serial bit moved near a clock edge");

    a_busy_after: assert property ((st.state == SAC_SHIFT) && st.sh_on |=> o_busy)
        else $error("busy fell before serial frame done");

    a_shift_half: assert property ((st.state == SAC_CONV) && st.sh_on |-> (st.cnt >= A_HALF))
        else $error("serial activity in late conversion");

    a_overrun_pulse: assert property (o_read_overrun_flag |-> !o_busy ##1 !o_read_overrun_flag)
        else $error("overrun flag not a pulse");
endmodule : sac_adc_ctrl

//--- tb/sac_host_model.sv
// Host model that clocks the external serial read
`timescale 1ns/10ps
module sac_host_model (
    input wire logic i_go,
    input wire logic i_serial_data_out,
    output logic o_sclk,
    output logic [15:0] o_word,
    output logic o_done
);
    initial begin
        o_sclk = 1'b0;
        o_word = 16'h0000;
        o_done = 1'b0;
    end
    // ----------------------------------------
    // Sixteen pulses per frame, clock idle low
    // ----------------------------------------
    always @(posedge i_go) begin
        o_done = 1'b0;
        #17.3;
        for (int i = 0; i < 16; i++) begin
            #62.5 o_word = {o_word[14:0], i_serial_data_out};
            o_sclk = 1'b1;
            #62.5 o_sclk = 1'b0;
        end
        o_done = 1'b1;
    end
endmodule : sac_host_model

//--- tb/sac_adc_ctrl_test.sv
// Self-checking bench of the converter control block
`timescale 1ns/10ps
module sac_adc_ctrl_test;
    import sac_pkg::*;
    logic clk, rst, sclk, convert_start_n_n, pd, cs_n, rd_n, cod, ser, swp, ext, rdc, inv, go;
    logic busy, ovf, lp, xsd, xoe, mdone, pc, c;
    logic [1:0] mode;
    logic [15:0] code, prv, sw, ex, mword, ew, ow, data, oe;
    logic [15:0] exp_q[$];
    logic [15:0] obs_q[$];
    int n_mismatch, total_checks, w, nb, ov, t, g, n, k;
    event got;

    sac_adc_ctrl DUT (.i_clk_sys(clk), .i_rst(rst), .i_sclk_link(sclk), .i_convert_start_n(convert_start_n_n),
        .i_power_down_input(pd), .i_mode_sel(mode), .i_chip_select_n(cs_n), .i_read_enable_n(rd_n),
        .i_output_coding_select(cod), .i_serial_parallel_select(ser), .i_byte_order_select(swp),
        .i_clock_source_select(ext), .i_read_timing_or_chain_in(rdc), .i_sclk_invert(inv),
        .i_sar_code(code), .o_busy(busy), .o_data(data), .o_data_oe(oe), .o_read_overrun_flag(ovf),
        .o_low_power(lp), .o_ext_serial_data_out(xsd), .o_ext_serial_data_out_oe(xoe));
    sac_host_model HOST (.i_go(go), .i_serial_data_out(xsd), .o_sclk(sclk), .o_word(mword), .o_done(mdone));

    always #5 clk = ~clk;

    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(got) begin
        while (obs_q.size() > 0) begin
            ew = exp_q.pop_front();
            ow = obs_q.pop_front();
            total_checks++;
            if (ow !== ew) begin
                n_mismatch++;
                $display("wrong value at %0t: got %h expected %h", $time, ow, ew);
            end
        end
    end

    task chk(input logic [15:0] e, input logic [15:0] o);
        exp_q.push_back(e);
        obs_q.push_back(o);
        -> got;
    endtask : chk

    task stop_test;
        #1;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    task cyc(input int m);
        repeat (m) @(posedge clk);
        #1;
    endtask : cyc

    task limit(input int m);
        if (m > 1000) begin
            n_mismatch++;
            $display("wait limit reached at %0t", $time);
            stop_test();
        end
    endtask : limit

    task pins(input logic s, input logic r);
        @(posedge clk);
        cs_n <= s;
        rd_n <= r;
    endtask : pins

    function automatic logic [15:0] enc(input logic [15:0] v);
        enc = cod ? v : {~v[15], v[14:0]};
    endfunction : enc

    // Start one conversion, stray start and power-down mid-run, gather serial bits
    task run(input logic keep);
        @(posedge clk);
        convert_start_n_n <= 1'b0;
        n = 0;
        while (busy !== 1'b1) begin
            cyc(1);
            n++;
            limit(n * 20);
        end
        w = 1;
        t = 0;
        nb = 0;
        ov = 0;
        pc = data[14] ^ inv;
        while (t < 6 && w < 600) begin
            @(posedge clk);
            convert_start_n_n <= (w > 20 && w < 40) ? 1'b0 : keep;
            pd <= (w > 20 && w < 60);
            #1;
            if (busy === 1'b1) w++;
            else t++;
            c = data[14] ^ inv;
            if (c && !pc && (data[13] ^ inv)) begin
                sw = {sw[14:0], data[15]};
                nb++;
            end
            pc = c;
            if (ovf === 1'b1) ov++;
        end
    endtask : run

    task idle;
        n = 0;
        while (busy !== 1'b0) begin
            cyc(1);
            n++;
            limit(n);
        end
    endtask : idle

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        convert_start_n_n = 1'b1;
        pd = 1'b0;
        mode = MODE_WARP;
        cs_n = 1'b1;
        rd_n = 1'b1;
        cod = 1'b0;
        ser = 1'b0;
        swp = 1'b0;
        ext = CLK_INTERNAL;
        rdc = RDC_AFTER;
        inv = 1'b0;
        go = 1'b0;
        code = 16'h0000;
        n_mismatch = 0;
        total_checks = 0;
        void'($urandom(76930));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        cyc(6);
        for (k = 0; k < 4; k++) begin
            pins(1'b1, 1'b1);
            code <= 16'($urandom);
            cod <= k[0];
            swp <= k[1];
            run(1'b1);
            chk(16'(w), 16'(CONV_WARP_CYC));
            chk(oe, 16'h0000);
            pins(1'b0, 1'b0);
            cyc(8);
            ex = enc(code);
            chk(oe, 16'hffff);
            chk(data, swp ? {ex[7:0], ex[15:8]} : ex);
        end
        $display("test parallel done");
        @(posedge clk);
        mode <= MODE_IMPULSE;
        cyc(6);
        run(1'b0);
        chk(16'(w), 16'(CONV_IMPULSE_CYC));
        g = 6;
        while (busy !== 1'b1 && g < 100) begin
            cyc(1);
            g++;
            if (g == 20) begin
                chk({15'h0000, lp}, 16'h0001);
                chk(oe, 16'hffff);
            end
        end
        chk(16'(g >= 44 && g <= 47), 16'h0001);
        cyc(5);
        chk({15'h0000, lp}, 16'h0000);
        chk(data, swp ? {ex[7:0], ex[15:8]} : ex);
        @(posedge clk);
        convert_start_n_n <= 1'b1;
        idle();
        @(posedge clk);
        mode <= MODE_WARP;
        cyc(6);
        run(1'b0);
        n = 0;
        repeat (100) begin
            cyc(1);
            if (busy === 1'b1) n++;
        end
        chk(16'(n), 16'h0000);
        @(posedge clk);
        convert_start_n_n <= 1'b1;
        ser <= 1'b1;
        cod <= 1'b1;
        $display("test restart done");
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            prv = code;
            code <= 16'($urandom);
            rdc <= (k < 2) ? RDC_AFTER : ~RDC_AFTER;
            inv <= k[0];
            cyc(6);
            run(1'b1);
            chk(16'(nb), 16'h0010);
            chk(sw, enc(rdc == RDC_AFTER ? code : prv));
            chk(16'(w), 16'(CONV_WARP_CYC) + ((rdc == RDC_AFTER) ? 16'h0041 : 16'h0000));
        end
        @(posedge clk);
        ext <= ~CLK_INTERNAL;
        rdc <= ~RDC_AFTER;
        pins(1'b1, 1'b1);
        cyc(6);
        chk({15'h0000, xoe}, 16'h0000);
        run(1'b1);
        run(1'b1);
        chk(16'(ov), 16'h0001);
        pins(1'b0, 1'b0);
        cyc(1);
        chk({15'h0000, xoe}, 16'h0001);
        @(posedge clk);
        go <= 1'b1;
        n = 0;
        while (mdone !== 1'b1) begin
            cyc(1);
            n++;
            limit(n * 2);
        end
        @(posedge clk);
        go <= 1'b0;
        chk(mword, enc(code));
        cyc(10);
        pins(1'b1, 1'b1);
        cyc(6);
        run(1'b1);
        chk(16'(ov), 16'h0000);
        $display("test serial done");
        stop_test();
    end
endmodule : sac_adc_ctrl_test
